// ### inc/two_wire_slave_port_defs.vh
`ifndef TWO_WIRE_SLAVE_PORT_DEFS_VH
`define TWO_WIRE_SLAVE_PORT_DEFS_VH

// --------------------------------------------------------------------------
// register indices, byte address is four times the index
// --------------------------------------------------------------------------
`define IDX_OWN_SLAVE_ADDRESS      8'he3
`define IDX_SERIAL_DATA_BUFFER     8'he4
`define IDX_SERIAL_PORT_CONTROL    8'he5
`define IDX_INTERRUPT_ENABLE_ONE   8'he6
`define IDX_SERIAL_PORT_STATUS     8'he8
`define IDX_SERIAL_DATA_BUFFER_ALT 8'he9
`define IDX_INTERRUPT_FLAGS_ONE    8'hf1
`define IDX_FILTER_AND_PIN_SELECT  8'hf2
`define IDX_INTERRUPT_PRIORITY_ONE 8'hf6

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define RST_OWN_SLAVE_ADDRESS      8'h00
`define RST_SERIAL_DATA_BUFFER     8'h00
`define RST_SERIAL_PORT_CONTROL    8'h10
`define RST_SERIAL_PORT_STATUS     8'h44
`define RST_FILTER_AND_PIN_SELECT  8'h40

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define CTL_SOFT_RESET     5
`define CTL_READ_STRETCH   4
`define CTL_WRITE_STRETCH  3
`define CTL_CLOCK_RELEASE  2
`define CTL_SLEW_LIMIT_OFF 1
`define CTL_PORT_ENABLE    0
`define STAT_WRITE_COLLIDE 1
`define STAT_RX_OVERRUN    0
`define IRQ_PORT_BIT       3
`define FILT_ANALOG        6
`define FILT_DIGITAL       5

// --------------------------------------------------------------------------
// timing counts
// --------------------------------------------------------------------------
`define DIG_FILTER_SAMPLES 3

`endif

// ### rtl/two_wire_slave_port.v
// Contract
// - own 7-bit address in bits 7..1
// - soft reset bit holds port in reset
// - read stretch holds clock low on reads
// - write stretch holds clock low on writes while the received byte is unread
// - clock release bit zero holds clock low
// - slew limit off selects standard mode
// - port takes part only when enabled
// - start detected flag set on start
// - stop flag reads one in stop state
// - direction bit recorded on address match
// - flag tells data byte from address
// - buffer full set after byte received
// - buffer full during transmit data bits
// - no acknowledge flag shows last ack slot
// - write during transmit discarded, collision flag
// - unread byte overrun drops new byte
// - one buffer serves both directions
// - interrupt flag bit 3 reports request
// - interrupt enable bit 3 gates delivery
// - analog filter select switches analog filter
// - digital filter select switches digital filter
// - priority bit 3 selects high priority
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`include "two_wire_slave_port_defs.vh"
module two_wire_slave_port #(
    parameter ADDR_W = 12
) (
    input  wire              clk_sys,
    input  wire              rstn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    input  wire              sclIn,
    output reg               sclOut,
    output reg               sclOe_n,
    input  wire              sdaIn,
    output reg               sdaOut,
    output reg               sdaOe_n,
    output reg               irqReq,
    output reg               irqHighPri,
    output reg               slewLimitOff,
    output reg               analogFilterOn,
    output reg               digitalFilterOn
);

localparam ST_IDLE   = 3'd0;
localparam ST_ADDR   = 3'd1;
localparam ST_WRITE  = 3'd2;
localparam ST_READ   = 3'd3;
localparam ST_IGNORE = 3'd4;

// --------------------------------------------------------------------------
// registers
// --------------------------------------------------------------------------
reg  [6:0] ownAddr_r;
reg  [7:0] dataBuf_r;
reg  [5:0] ctrl_r;
reg        irqEnable_r, irqFlag_r, irqPrio_r, anaFilt_r, digFilt_r;
reg        startSeen_r, stopSeen_r, readDir_r, dataNotAddr_r, bufFull_r;
reg        noAck_r, wrCollide_r, rxOverrun_r, ackNow_r, sdaDrive_r, stretch_r;
reg  [2:0] state_r;
reg  [3:0] bitCnt_r;
reg  [7:0] shift_r;

// --------------------------------------------------------------------------
// pin synchronisers and digital glitch filter
// --------------------------------------------------------------------------
wire [1:0] pinRaw = {sclIn, sdaIn};
reg  [1:0] pinMeta_r;
reg  [1:0] pinSync_r;
wire [1:0] pinFilt;
reg  [1:0] pinPrev_r;

genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : gFilt
        reg [1:0] stable_r;
        reg       level_r;
        always @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                pinMeta_r[g] <= 1'b1;
                pinSync_r[g] <= 1'b1;
                stable_r     <= 2'd0;
                level_r      <= 1'b1;
            end else begin
                pinMeta_r[g] <= pinRaw[g];
                pinSync_r[g] <= pinMeta_r[g];
                if (!digFilt_r || pinSync_r[g] == level_r) begin
                    stable_r <= 2'd0;
                    level_r  <= pinSync_r[g];
                end else if (stable_r == `DIG_FILTER_SAMPLES - 1) begin
                    stable_r <= 2'd0;
                    level_r  <= pinSync_r[g];
                end else begin
                    stable_r <= stable_r + 2'd1;
                end
            end
        end
        assign pinFilt[g] = level_r;
    end
endgenerate

wire sclNow  = pinFilt[1];
wire sdaNow  = pinFilt[0];
wire sclRise = sclNow & ~pinPrev_r[1];
wire sclFall = ~sclNow & pinPrev_r[1];
wire startEv = sclNow & pinPrev_r[1] & pinPrev_r[0] & ~sdaNow;
wire stopEv  = sclNow & pinPrev_r[1] & ~pinPrev_r[0] & sdaNow;

// --------------------------------------------------------------------------
// apb decode
// --------------------------------------------------------------------------
wire       access  = psel & penable & pready;
wire       wrEn    = access & pwrite;
wire       rdEn    = access & ~pwrite;
wire       upperOk = (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});
wire [7:0] regIdx  = paddr[9:2];
wire [7:0] wByte   = pwdata[7:0];

wire hitBuf  = upperOk && (regIdx == `IDX_SERIAL_DATA_BUFFER ||
                           regIdx == `IDX_SERIAL_DATA_BUFFER_ALT);
wire hitStat = upperOk && regIdx == `IDX_SERIAL_PORT_STATUS;
wire hitIrqF = upperOk && regIdx == `IDX_INTERRUPT_FLAGS_ONE;
wire bufWr   = wrEn & hitBuf;
wire bufRd   = rdEn & hitBuf;

wire [7:0] statusVal = {startSeen_r, stopSeen_r, readDir_r, dataNotAddr_r,
                        bufFull_r, noAck_r, wrCollide_r, rxOverrun_r};

reg        mapped;
reg  [7:0] rdByte;
always @* begin
    mapped = upperOk;
    rdByte = 8'h00;
    case (regIdx)
        `IDX_OWN_SLAVE_ADDRESS:      rdByte = {ownAddr_r, 1'b0};
        `IDX_SERIAL_DATA_BUFFER:     rdByte = dataBuf_r;
        `IDX_SERIAL_DATA_BUFFER_ALT: rdByte = dataBuf_r;
        `IDX_SERIAL_PORT_CONTROL:    rdByte = {2'b00, ctrl_r};
        `IDX_INTERRUPT_ENABLE_ONE:   rdByte = {4'h0, irqEnable_r, 3'h0};
        `IDX_SERIAL_PORT_STATUS:     rdByte = statusVal;
        `IDX_INTERRUPT_FLAGS_ONE:    rdByte = {4'h0, irqFlag_r, 3'h0};
        `IDX_FILTER_AND_PIN_SELECT:  rdByte = {1'b0, anaFilt_r, digFilt_r,
                                               5'h00};
        `IDX_INTERRUPT_PRIORITY_ONE: rdByte = {4'h0, irqPrio_r, 3'h0};
        default:                     mapped = 1'b0;
    endcase
end

// one wait state: pready rises in the second access cycle
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        pready  <= 1'b0;
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
    end else begin
        pready  <= psel & penable & ~pready;
        pslverr <= psel & penable & ~pready & ~mapped;
        if (psel & penable & ~pready & ~pwrite) begin
            prdata <= {24'h00_0000, rdByte};
        end
    end
end

// --------------------------------------------------------------------------
// software registers
// --------------------------------------------------------------------------
wire portRun = ctrl_r[`CTL_PORT_ENABLE] & ~ctrl_r[`CTL_SOFT_RESET];

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        ownAddr_r   <= 7'h00;
        ctrl_r      <= 6'h10;
        anaFilt_r   <= 1'b1;
        {irqEnable_r, irqPrio_r, digFilt_r} <= 3'b000;
    end else if (wrEn && upperOk) begin
        case (regIdx)
            `IDX_OWN_SLAVE_ADDRESS:      ownAddr_r <= wByte[7:1];
            `IDX_SERIAL_PORT_CONTROL:    ctrl_r <= wByte[5:0];
            `IDX_INTERRUPT_ENABLE_ONE:
                irqEnable_r <= wByte[`IRQ_PORT_BIT];
            `IDX_FILTER_AND_PIN_SELECT: begin
                anaFilt_r <= wByte[`FILT_ANALOG];
                digFilt_r <= wByte[`FILT_DIGITAL];
            end
            `IDX_INTERRUPT_PRIORITY_ONE: irqPrio_r <= wByte[`IRQ_PORT_BIT];
            default: ;
        endcase
    end
end

// --------------------------------------------------------------------------
// bus protocol engine
// --------------------------------------------------------------------------
wire [7:0] byteIn   = {shift_r[6:0], sdaNow};
wire       txLoad   = stretch_r & (state_r == ST_READ) & bufWr & ~bufFull_r;
wire       collide  = bufWr & (state_r == ST_READ) & bufFull_r;
wire       rxDone   = sclRise & (state_r == ST_WRITE) & (bitCnt_r == 4'd7);
wire       addrDone = sclRise & (state_r == ST_ADDR) & (bitCnt_r == 4'd7);
wire       addrHit  = byteIn[7:1] == ownAddr_r;
wire       ackSlot  = sclRise & (state_r == ST_READ) & (bitCnt_r == 4'd8);

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        state_r       <= ST_IDLE;
        bitCnt_r      <= 4'd0;
        shift_r       <= 8'h00;
        {ackNow_r, sdaDrive_r, stretch_r} <= 3'b000;
        dataBuf_r     <= `RST_SERIAL_DATA_BUFFER;
        {startSeen_r, stopSeen_r, readDir_r, dataNotAddr_r, bufFull_r,
         noAck_r, wrCollide_r, rxOverrun_r} <= `RST_SERIAL_PORT_STATUS;
        irqFlag_r     <= 1'b0;
        pinPrev_r     <= 2'b11;
    end else if (ctrl_r[`CTL_SOFT_RESET]) begin
        state_r       <= ST_IDLE;
        bitCnt_r      <= 4'd0;
        {ackNow_r, sdaDrive_r, stretch_r} <= 3'b000;
        {startSeen_r, stopSeen_r, readDir_r, dataNotAddr_r, bufFull_r,
         noAck_r, wrCollide_r, rxOverrun_r} <= `RST_SERIAL_PORT_STATUS;
        pinPrev_r     <= pinFilt;
    end else begin
        pinPrev_r <= pinFilt;
        if (wrEn && hitStat) begin
            wrCollide_r <= wByte[`STAT_WRITE_COLLIDE];
            rxOverrun_r <= wByte[`STAT_RX_OVERRUN];
        end
        if (wrEn && hitIrqF) begin
            irqFlag_r <= wByte[`IRQ_PORT_BIT];
        end
        if (bufWr && !collide) begin
            dataBuf_r <= wByte;
        end
        if (bufRd && state_r != ST_READ) begin
            bufFull_r <= 1'b0;
        end
        if (collide) begin
            wrCollide_r <= 1'b1;
        end
        if (txLoad) begin
            stretch_r  <= 1'b0;
            shift_r    <= wByte;
            bufFull_r  <= 1'b1;
            sdaDrive_r <= ~wByte[7];
        end
        if (stretch_r && state_r == ST_WRITE && bufRd) begin
            stretch_r <= 1'b0;
        end

        if (!portRun) begin
            state_r    <= ST_IDLE;
            sdaDrive_r <= 1'b0;
            stretch_r  <= 1'b0;
        end else if (startEv) begin
            state_r     <= ST_ADDR;
            bitCnt_r    <= 4'd0;
            sdaDrive_r  <= 1'b0;
            stretch_r   <= 1'b0;
            {startSeen_r, stopSeen_r} <= 2'b10;
        end else if (stopEv) begin
            state_r     <= ST_IDLE;
            sdaDrive_r  <= 1'b0;
            stretch_r   <= 1'b0;
            {startSeen_r, stopSeen_r} <= 2'b01;
        end else if (state_r != ST_IDLE && state_r != ST_IGNORE) begin
            if (sclRise) begin
                bitCnt_r <= bitCnt_r + 4'd1;
                if (bitCnt_r < 4'd8) begin
                    shift_r <= byteIn;
                end
            end
            if (addrDone) begin
                if (addrHit) begin
                    readDir_r     <= sdaNow;
                    dataNotAddr_r <= 1'b0;
                    ackNow_r      <= 1'b1;
                    irqFlag_r     <= 1'b1;
                end else begin
                    state_r <= ST_IGNORE;
                end
            end
            if (rxDone) begin
                dataNotAddr_r <= 1'b1;
                irqFlag_r     <= 1'b1;
                if (bufFull_r && !(bufRd)) begin
                    rxOverrun_r <= 1'b1;
                    ackNow_r    <= 1'b0;
                end else begin
                    dataBuf_r <= byteIn;
                    bufFull_r <= 1'b1;
                    ackNow_r  <= 1'b1;
                end
            end
            if (sclRise && state_r == ST_READ && bitCnt_r == 4'd7) begin
                bufFull_r     <= 1'b0;
                dataNotAddr_r <= 1'b1;
            end
            if (sclRise && state_r != ST_READ && bitCnt_r == 4'd8) begin
                noAck_r <= ~ackNow_r;
            end
            if (ackSlot) begin
                noAck_r   <= sdaNow;
                irqFlag_r <= 1'b1;
                if (sdaNow) begin
                    state_r <= ST_IGNORE;
                end
            end
            if (sclFall) begin
                if (bitCnt_r == 4'd8) begin
                    sdaDrive_r <= ackNow_r & (state_r != ST_READ);
                end else if (bitCnt_r == 4'd9) begin
                    bitCnt_r   <= 4'd0;
                    sdaDrive_r <= 1'b0;
                    ackNow_r   <= 1'b0;
                    if (state_r == ST_ADDR) begin
                        state_r <= readDir_r ? ST_READ : ST_WRITE;
                    end
                    if (state_r == ST_READ ||
                        (state_r == ST_ADDR && readDir_r)) begin
                        if (ctrl_r[`CTL_READ_STRETCH]) begin
                            stretch_r <= 1'b1;
                        end else begin
                            shift_r    <= dataBuf_r;
                            bufFull_r  <= 1'b1;
                            sdaDrive_r <= ~dataBuf_r[7];
                        end
                    end else if (ctrl_r[`CTL_WRITE_STRETCH] &&
                                 state_r == ST_WRITE && bufFull_r) begin
                        stretch_r <= 1'b1;
                    end
                end else if (state_r == ST_READ && !stretch_r) begin
                    sdaDrive_r <= ~shift_r[7];
                end
            end
        end
    end
end

// --------------------------------------------------------------------------
// registered outputs
// --------------------------------------------------------------------------
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        {sclOut, sdaOut, irqReq, irqHighPri} <= 4'h0;
        {slewLimitOff, digitalFilterOn} <= 2'b00;
        {sclOe_n, sdaOe_n, analogFilterOn} <= 3'b111;
    end else begin
        sclOut          <= 1'b0;
        sclOe_n         <= ~(portRun & (~ctrl_r[`CTL_CLOCK_RELEASE] |
                                        stretch_r));
        sdaOut          <= 1'b0;
        sdaOe_n         <= ~(portRun & sdaDrive_r);
        irqReq          <= irqFlag_r & irqEnable_r;
        irqHighPri      <= irqPrio_r;
        slewLimitOff    <= ctrl_r[`CTL_SLEW_LIMIT_OFF];
        analogFilterOn  <= anaFilt_r;
        digitalFilterOn <= digFilt_r;
    end
end

endmodule // two_wire_slave_port

// ### test/test_two_wire_slave_port.sv
`timescale 1ns/100ps
`include "two_wire_slave_port_defs.vh"
module test_two_wire_slave_port;
    localparam [7:0] ADR = `IDX_OWN_SLAVE_ADDRESS;
    localparam [7:0] BUF = `IDX_SERIAL_DATA_BUFFER;
    localparam [7:0] CTL = `IDX_SERIAL_PORT_CONTROL;
    localparam [7:0] IEN = `IDX_INTERRUPT_ENABLE_ONE;
    localparam [7:0] STA = `IDX_SERIAL_PORT_STATUS;
    localparam [7:0] ALT = `IDX_SERIAL_DATA_BUFFER_ALT;
    localparam [7:0] FLG = `IDX_INTERRUPT_FLAGS_ONE;
    localparam [7:0] FIL = `IDX_FILTER_AND_PIN_SELECT;
    localparam [7:0] PRI = `IDX_INTERRUPT_PRIORITY_ONE;
    logic        clk_sys = 1'h0;
    logic        rstn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, sclOut, sclOe_n, sdaOut, sdaOe_n;
    wire         irqReq, irqHighPri, slewLimitOff;
    wire         analogFilterOn, digitalFilterOn, sclDrv, sdaDrv;
    wire         sclLine = sclDrv & (sclOe_n | sclOut);
    wire         sdaLine = sdaDrv & (sdaOe_n | sdaOut);
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    logic [31:0] rd;
    logic        err;
    logic        ak;
    logic [7:0]  rb;

    always #20 clk_sys = ~clk_sys;

    two_wire_slave_port dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclIn(sclLine),
        .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .irqReq(irqReq),
        .irqHighPri(irqHighPri), .slewLimitOff(slewLimitOff),
        .analogFilterOn(analogFilterOn), .digitalFilterOn(digitalFilterOn)
    );
    two_wire_master_model mst_u (
        .sclLine(sclLine), .sdaLine(sdaLine),
        .sclDrv(sclDrv), .sdaDrv(sdaDrv)
    );

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n == 20) begin
            num_errors++;
            end_of_test;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 8'h00);
        check(rd, exp);
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test;
        end
    end

    initial begin
        tick(12);
        rstn <= 1'h1;
        rdc(CTL, 32'h10);
        rdc(STA, 32'h44);
        rdc(FIL, 32'h40);
        rdc(ADR, 32'h00);
        rdc(IEN, 32'h00);
        rdc(BUF, 32'h00);
        rdc(8'h10, 32'h00);
        check(err, 1'h1);
        check(sclOe_n & sdaOe_n, 1'h1);
        $display("reset test done");
        apb(1'h1, ADR, 8'hb4);
        rdc(ADR, 32'hb4);
        mst_u.start;
        mst_u.sendByte(8'hb4, ak);
        check(ak, 1'h1);
        mst_u.stop;
        apb(1'h1, FIL, 8'h20);
        apb(1'h1, PRI, 8'h08);
        apb(1'h1, CTL, 8'h13);
        tick(3);
        check(digitalFilterOn, 1'h1);
        check(analogFilterOn, 1'h0);
        check(irqHighPri, 1'h1);
        check(slewLimitOff, 1'h1);
        check(sclOe_n, 1'h0);
        apb(1'h1, FIL, 8'h40);
        apb(1'h1, CTL, 8'h15);
        apb(1'h1, IEN, 8'h08);
        tick(3);
        check(slewLimitOff, 1'h0);
        check(sclOe_n, 1'h1);
        $display("config test done");
        mst_u.start;
        mst_u.sendByte(8'hb4, ak);
        check(ak, 1'h0);
        tick(2);
        check(irqReq, 1'h1);
        apb(1'h0, STA, 8'h00);
        check({rd[7:4], rd[2]}, 5'h10);
        apb(1'h1, FLG, 8'h00);
        tick(3);
        check(irqReq, 1'h0);
        mst_u.sendByte(8'h3c, ak);
        check(ak, 1'h0);
        apb(1'h0, STA, 8'h00);
        check(rd[4:3], 2'h3);
        mst_u.sendByte(8'hc3, ak);
        check(ak, 1'h1);
        rdc(BUF, 32'h3c);
        apb(1'h0, STA, 8'h00);
        check(rd[3:0], 4'h5);
        apb(1'h1, STA, 8'h00);
        rdc(ALT, 32'h3c);
        apb(1'h0, STA, 8'h00);
        check(rd[0], 1'h0);
        mst_u.stop;
        apb(1'h0, STA, 8'h00);
        check(rd[7:6], 2'h1);
        apb(1'h1, IEN, 8'h00);
        apb(1'h0, FLG, 8'h00);
        check(rd[3], 1'h1);
        check(irqReq, 1'h0);
        apb(1'h1, FLG, 8'h00);
        apb(1'h1, IEN, 8'h08);
        mst_u.start;
        mst_u.sendByte(8'hb6, ak);
        check(ak, 1'h1);
        mst_u.sendByte(8'h00, ak);
        check(ak, 1'h1);
        mst_u.stop;
        $display("write test done");
        apb(1'h1, CTL, 8'h1d);
        mst_u.start;
        mst_u.sendByte(8'hb4, ak);
        mst_u.sendByte(8'h11, ak);
        fork
            mst_u.sendByte(8'h22, ak);
            begin
                tick(10);
                check(sclOe_n, 1'h0);
                rdc(BUF, 32'h11);
            end
        join
        check(ak, 1'h0);
        rdc(BUF, 32'h22);
        mst_u.stop;
        apb(1'h1, CTL, 8'h15);
        mst_u.start;
        mst_u.sendByte(8'hb5, ak);
        check(ak, 1'h0);
        tick(8);
        check(sclOe_n, 1'h0);
        apb(1'h0, STA, 8'h00);
        check(rd[5], 1'h1);
        fork
            mst_u.getByte(1'h1, rb);
            begin
                apb(1'h1, BUF, 8'ha5);
                apb(1'h0, STA, 8'h00);
                check(rd[3], 1'h1);
                apb(1'h1, BUF, 8'h5a);
            end
        join
        check(rb, 8'ha5);
        apb(1'h0, STA, 8'h00);
        check(rd[3:1], 3'h3);
        mst_u.stop;
        $display("stretch test done");
        mst_u.start;
        mst_u.sendByte(8'hb4, ak);
        apb(1'h1, CTL, 8'h35);
        rdc(STA, 32'h44);
        check(sclOe_n & sdaOe_n, 1'h1);
        apb(1'h1, CTL, 8'h15);
        rdc(ADR, 32'hb4);
        mst_u.stop;
        mst_u.start;
        mst_u.sendByte(8'hb4, ak);
        check(ak, 1'h0);
        mst_u.stop;
        $display("soft reset test done");
        end_of_test;
    end
endmodule // test_two_wire_slave_port

// ### test/two_wire_master_model.sv
`timescale 1ns/100ps
module two_wire_master_model (
    input  wire  sclLine,
    input  wire  sdaLine,
    output logic sclDrv,
    output logic sdaDrv
);
    initial begin
        sclDrv = 1'h1;
        sdaDrv = 1'h1;
    end
    // keeps pin changes away from the system clock edge
    task automatic phase;
        #((47 - $time % 40) % 40);
    endtask
    task automatic sclHigh;
        int n;
        n = 0;
        sclDrv = 1'h1;
        while (sclLine !== 1'h1 && n < 500) begin
            #40;
            n++;
        end
    endtask
    task automatic bitOut(input logic b);
        sdaDrv = b;
        #120;
        sclHigh;
        #120;
        sclDrv = 1'h0;
        #80;
    endtask
    task automatic bitIn(output logic b);
        sdaDrv = 1'h1;
        #120;
        sclHigh;
        #80;
        b = sdaLine;
        #40;
        sclDrv = 1'h0;
        #80;
    endtask
    task automatic start;
        phase;
        sdaDrv = 1'h1;
        sclDrv = 1'h1;
        #160;
        sdaDrv = 1'h0;
        #160;
        sclDrv = 1'h0;
        #80;
    endtask
    task automatic stop;
        phase;
        sdaDrv = 1'h0;
        #80;
        sclHigh;
        #160;
        sdaDrv = 1'h1;
        #160;
    endtask
    task automatic sendByte(input logic [7:0] d, output logic ack);
        phase;
        for (int i = 7; i >= 0; i--)
            bitOut(d[i]);
        bitIn(ack);
    endtask
    task automatic getByte(input logic ackBit, output logic [7:0] d);
        logic b;
        phase;
        for (int i = 7; i >= 0; i--) begin
            bitIn(b);
            d[i] = b;
        end
        bitOut(ackBit);
    endtask
endmodule // two_wire_master_model

// ### test/two_wire_slave_port_monitor.sv
`timescale 1ns/100ps
`include "two_wire_slave_port_defs.vh"
module two_wire_slave_port_monitor #(
    parameter ADDR_W = 12
) (
    input wire              clk_sys,
    input wire              rstn,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0]       pwdata,
    input wire [31:0]       prdata,
    input wire              pready,
    input wire              pslverr,
    input wire              sclIn,
    input wire              sclOut,
    input wire              sclOe_n,
    input wire              sdaIn,
    input wire              sdaOut,
    input wire              sdaOe_n,
    input wire              irqReq,
    input wire              irqHighPri,
    input wire              slewLimitOff,
    input wire              analogFilterOn,
    input wire              digitalFilterOn
);
    wire [7:0] idx = paddr[9:2];
    wire       hit = psel && penable && pready;
    wire       mapped = (paddr[ADDR_W-1:10] == '0) && (idx inside {
        `IDX_OWN_SLAVE_ADDRESS, `IDX_SERIAL_DATA_BUFFER,
        `IDX_SERIAL_PORT_CONTROL, `IDX_INTERRUPT_ENABLE_ONE,
        `IDX_SERIAL_PORT_STATUS, `IDX_SERIAL_DATA_BUFFER_ALT,
        `IDX_INTERRUPT_FLAGS_ONE, `IDX_FILTER_AND_PIN_SELECT,
        `IDX_INTERRUPT_PRIORITY_ONE});
    wire       wrHit = hit && pwrite && mapped;
    wire       ctlWr = wrHit && idx == `IDX_SERIAL_PORT_CONTROL;
    wire       filWr = wrHit && idx == `IDX_FILTER_AND_PIN_SELECT;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    AST_APB_ONE_WAIT: assert property (
        psel && $rose(penable) |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_SLVERR_UNMAPPED: assert property (hit |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    AST_SLEW_FOLLOWS: assert property (
        ctlWr |-> ##2 slewLimitOff == $past(pwdata[`CTL_SLEW_LIMIT_OFF], 2))
        else $error("slew output not as written");
    AST_ANALOG_FOLLOWS: assert property (
        filWr |-> ##2 analogFilterOn == $past(pwdata[`FILT_ANALOG], 2))
        else $error("analog filter output not as written");
    AST_DIGITAL_FOLLOWS: assert property (
        filWr |-> ##2 digitalFilterOn == $past(pwdata[`FILT_DIGITAL], 2))
        else $error("digital filter output not as written");
    AST_PRIORITY_FOLLOWS: assert property (
        wrHit && idx == `IDX_INTERRUPT_PRIORITY_ONE
        |-> ##2 irqHighPri == $past(pwdata[`IRQ_PORT_BIT], 2))
        else $error("priority output not as written");
    AST_IRQ_MASKED: assert property (
        wrHit && idx == `IDX_INTERRUPT_ENABLE_ONE
        && !pwdata[`IRQ_PORT_BIT] |-> ##2 !irqReq)
        else $error("interrupt delivered while disabled");
    AST_SCL_HELD_LOW: assert property (
        ctlWr && pwdata[`CTL_PORT_ENABLE] && !pwdata[`CTL_CLOCK_RELEASE]
        && !pwdata[`CTL_SOFT_RESET] |-> ##[1:4] !sclOe_n)
        else $error("clock line not held low");
    AST_SOFT_RESET_FREE: assert property (
        ctlWr && pwdata[`CTL_SOFT_RESET] |-> ##[1:4] sclOe_n && sdaOe_n)
        else $error("pins driven during soft reset");

    cover property (ctlWr);
    cover property ($fell(sclOe_n));
    cover property (hit && pslverr);
    cover property ($rose(irqReq));
endmodule // two_wire_slave_port_monitor

bind two_wire_slave_port two_wire_slave_port_monitor #(.ADDR_W(ADDR_W))
    mon_u (.*);
